// ==== rtl/cad_regs.svh ====
`ifndef CAD_REGS_SVH
`define CAD_REGS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CAD_OFS_STATUS     8'h00
`define CAD_OFS_MODCTL     8'h04
`define CAD_OFS_SCAN       8'h08
`define CAD_OFS_CHSEL      8'h0c
`define CAD_OFS_HI_THR     8'h10
`define CAD_OFS_LO_THR     8'h14
`define CAD_OFS_HI_DB      8'h18
`define CAD_OFS_LO_DB      8'h1c
`define CAD_OFS_OFFSET     8'h20
`define CAD_OFS_ENABLES    8'h24
`define CAD_OFS_DIAG       8'h28
`define CAD_OFS_DIAG_LEN   8'h2c
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CAD_ST_OK_BIT      0
`define CAD_ST_WDOG_BIT    15
`define CAD_ST_RAM_BIT     16
`define CAD_ST_IF_BIT      17
`define CAD_DG_LO_BIT      0
`define CAD_DG_HI_BIT      1
`define CAD_DG_OPEN_BIT    4
`define CAD_DG_NEW_BIT     23
`define CAD_DG_ERR_BIT     24
`define CAD_DG_BITF_BIT    28
`define CAD_DG_IIC_BIT     29
`define CAD_DG_ICS_BIT     30
`define CAD_RST_HI_THR     32'sh00040000
`define CAD_RST_LO_THR     32'sh00000100
`define CAD_RST_HI_DB      32'sh00000100
`define CAD_RST_LO_DB      32'sh00000100
`define CAD_RST_OFFSET     32'sh00000000
`define CAD_RST_GROUP      4'h1
`define CAD_NUM_CH         15
`define CAD_SCAN_DIV       16'h0063
`endif

// ==== rtl/cad_pkg.sv ====
package cad_pkg;
	// Per-channel enables
	typedef struct packed {
		logic diag_en;
		logic fault_en;
		logic lo_en;
		logic hi_en;
		logic open_en;
		logic new_en;
		logic err_en;
		logic bitf_en;
		logic iic_en;
		logic ics_en;
	} cad_enables_t;
	// Per-channel thresholds, signed 24.8 fixed point
	typedef struct packed {
		logic signed [31:0] hi_thr;
		logic signed [31:0] lo_thr;
		logic signed [31:0] hi_db;
		logic signed [31:0] lo_db;
		logic signed [31:0] offset;
	} cad_limits_t;
	// One reading from the transducer front end
	typedef struct packed {
		logic               valid;
		logic [3:0]         ch;
		logic signed [31:0] value;
		logic               ok;
		logic               err_resp;
		logic               bit_fail;
		logic               invalid_input_condition_fault;
		logic               ics_fail;
	} cad_reading_t;
	// Sweep state
	typedef enum logic [1:0] {
		CAD_SW_IDLE,
		CAD_SW_RUN,
		CAD_SW_DONE
	} cad_sweep_t;
endpackage

// ==== rtl/cad_alarm_eval.sv ====
`timescale 1ns/1ps
`include "cad_regs.svh"
// ----------------------------------------
// Alarm evaluator with deadband hysteresis
// ----------------------------------------
module cad_alarm_eval
	import cad_pkg::*;
(
	input  logic signed [31:0] value,
	input  cad_limits_t        lim,
	input  logic               hi_on,
	input  logic               lo_on,
	input  logic               hi_prev,
	input  logic               lo_prev,
	output logic               hi_next,
	output logic               lo_next
);
	logic signed [32:0] adj;        // Value plus user offset
	logic signed [32:0] hi_rel;     // High release level
	logic signed [32:0] lo_rel;     // Low release level
	assign adj    = 33'(value) + 33'(lim.offset);
	assign hi_rel = 33'(lim.hi_thr) - 33'(lim.hi_db);
	assign lo_rel = 33'(lim.lo_thr) + 33'(lim.lo_db);
	// High alarm sets at threshold, holds through deadband
	always_comb begin
		if (!hi_on) begin
			hi_next = 1'b0;
		end else if (adj >= 33'(lim.hi_thr)) begin
			hi_next = 1'b1;
		end else if (hi_prev && adj >= hi_rel) begin
			hi_next = 1'b1;
		end else begin
			hi_next = 1'b0;
		end
	end
	// Low alarm sets at threshold, holds through deadband
	always_comb begin
		if (!lo_on) begin
			lo_next = 1'b0;
		end else if (adj <= 33'(lim.lo_thr)) begin
			lo_next = 1'b1;
		end else if (lo_prev && adj <= lo_rel) begin
			lo_next = 1'b1;
		end else begin
			lo_next = 1'b0;
		end
	end
endmodule

// ==== rtl/cad_channel_alarm_diag.sv ====
`timescale 1ns/1ps
`include "cad_regs.svh"
module cad_channel_alarm_diag
	import cad_pkg::*;
(
	input  logic         aclk,
	input  logic         aresetn,
	input  logic [7:0]   s_axi_awaddr,
	input  logic         s_axi_awvalid,
	output logic         s_axi_awready,
	input  logic [31:0]  s_axi_wdata,
	input  logic [3:0]   s_axi_wstrb,
	input  logic         s_axi_wvalid,
	output logic         s_axi_wready,
	output logic [1:0]   s_axi_bresp,
	output logic         s_axi_bvalid,
	input  logic         s_axi_bready,
	input  logic [7:0]   s_axi_araddr,
	input  logic         s_axi_arvalid,
	output logic         s_axi_arready,
	output logic [31:0]  s_axi_rdata,
	output logic [1:0]   s_axi_rresp,
	output logic         s_axi_rvalid,
	input  logic         s_axi_rready,
	input  cad_reading_t rd_in,
	input  logic         scan_done,
	input  logic         wdog_fail,
	input  logic         ram_fail,
	input  logic         if_fail,
	output logic [3:0]   scan_group,
	output logic         scan_start,
	output logic         fault_evt,
	output logic [3:0]   fault_ch
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	localparam int NCH = `CAD_NUM_CH;
	cad_limits_t        lim_ff   [NCH];   // Per-channel limits
	cad_enables_t       en_ff    [NCH];   // Per-channel enables
	logic [3:0]         grp_ff   [NCH];   // Scan group per channel
	logic [31:0]        diag_ff  [NCH];   // Diagnostic word per channel
	logic [3:0]         chsel_ff;         // Channel window select
	logic [15:0]        diag_len_ff;      // Diagnostic length
	logic [2:0]         fail_ff;          // Latched module failures
	logic               mod_en_ff;        // Module enable (present)
	logic [3:0]         grp_cur_ff;       // Group being swept
	logic [15:0]        div_ff;           // Sweep rate divider
	logic               scan_start_ff;    // Sweep pulse
	cad_sweep_t         sw_ff;            // Sweep state
	logic               fault_evt_ff;     // Fault event pulse
	logic [3:0]         fault_ch_ff;      // Fault event channel
	logic               aw_ok_ff;         // Write address held
	logic               w_ok_ff;          // Write data held
	logic [7:0]         awaddr_ff;        // Held write address
	logic [31:0]        wdata_ff;         // Held write data
	logic [3:0]         wstrb_ff;         // Held byte enables
	logic               bvalid_ff;        // Write response valid
	logic [1:0]         bresp_ff;         // Write response code
	logic               rvalid_ff;        // Read response valid
	logic [31:0]        rdata_ff;         // Read data
	logic [1:0]         rresp_ff;         // Read response code
	cad_reading_t       rd_ff;            // Registered reading
	logic               hi_nx;            // Evaluated high alarm
	logic               lo_nx;            // Evaluated low alarm
	logic [31:0]        status;           // Module health word
	logic [31:0]        nxt_diag;         // Updated diagnostic word
	logic               evt_raise;        // New reportable event
	logic               pre_wdog;         // Failure pin first stage
	logic               pre_ram;          // Failure pin first stage
	logic               pre_if;           // Failure pin first stage
	logic [2:0]         fail_sync;        // Failure pins synchronised

	// Byte-lane merge used by the per-channel limit registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Address decode used by read and write sides
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= `CAD_OFS_DIAG_LEN);
	endfunction

	// ----------------------------------------
	// Failure pin synchronisers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{pre_wdog, pre_ram, pre_if} <= 3'h0;
			fail_sync                   <= 3'h0;
		end else begin
			{pre_wdog, pre_ram, pre_if} <= {wdog_fail, ram_fail, if_fail};
			fail_sync                   <= {pre_wdog, pre_ram, pre_if};
		end
	end

	// Latch failures until reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_ff <= 3'h0;
		end else begin
			fail_ff <= fail_ff | fail_sync;
		end
	end

	// Module health word, reserved bits zero
	always_comb begin
		status                   = 32'h0000_0000;
		status[`CAD_ST_OK_BIT]   = mod_en_ff && (fail_ff == 3'h0);
		status[`CAD_ST_WDOG_BIT] = fail_ff[2];
		status[`CAD_ST_RAM_BIT]  = fail_ff[1];
		status[`CAD_ST_IF_BIT]   = fail_ff[0];
	end

	// ----------------------------------------
	// AXI4-Lite write side
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_ff  <= 1'b0;
			w_ok_ff   <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= 2'b00;
		end else begin
			// Capture address and data in either order
			if (s_axi_awvalid && !aw_ok_ff && !bvalid_ff) begin
				aw_ok_ff  <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_ok_ff && !bvalid_ff) begin
				w_ok_ff  <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			// Answer once both have arrived
			if (aw_ok_ff && w_ok_ff) begin
				aw_ok_ff  <= 1'b0;
				w_ok_ff   <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= mapped(awaddr_ff) ? 2'b00 : 2'b10;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	wire wr_go = aw_ok_ff && w_ok_ff; // Write commits this cycle

	// Global control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mod_en_ff   <= 1'b1;
			chsel_ff    <= 4'h0;
			diag_len_ff <= 16'h0000;
		end else if (wr_go) begin
			case (awaddr_ff)
				`CAD_OFS_MODCTL: begin
					if (wstrb_ff[0]) mod_en_ff <= wdata_ff[0];
				end
				`CAD_OFS_CHSEL: begin
					if (wstrb_ff[0]) chsel_ff <= wdata_ff[3:0];
				end
				`CAD_OFS_DIAG_LEN: begin
					if (wstrb_ff[0]) diag_len_ff[7:0]  <= wdata_ff[7:0];
					if (wstrb_ff[1]) diag_len_ff[15:8] <= wdata_ff[15:8];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Per-channel configuration, reset to defaults
	// ----------------------------------------
	for (genvar c = 0; c < NCH; c++) begin : g_cfg
		wire sel = wr_go && (chsel_ff == 4'(c)); // This channel addressed
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				lim_ff[c] <= '{`CAD_RST_HI_THR, `CAD_RST_LO_THR, `CAD_RST_HI_DB,
					`CAD_RST_LO_DB, `CAD_RST_OFFSET};
				en_ff[c]  <= '0;
				grp_ff[c] <= `CAD_RST_GROUP;
			end else if (sel) begin
				case (awaddr_ff)
					`CAD_OFS_HI_THR: lim_ff[c].hi_thr <= merge(lim_ff[c].hi_thr, wdata_ff, wstrb_ff);
					`CAD_OFS_LO_THR: lim_ff[c].lo_thr <= merge(lim_ff[c].lo_thr, wdata_ff, wstrb_ff);
					`CAD_OFS_HI_DB:  lim_ff[c].hi_db  <= merge(lim_ff[c].hi_db, wdata_ff, wstrb_ff);
					`CAD_OFS_LO_DB:  lim_ff[c].lo_db  <= merge(lim_ff[c].lo_db, wdata_ff, wstrb_ff);
					`CAD_OFS_OFFSET: lim_ff[c].offset <= merge(lim_ff[c].offset, wdata_ff, wstrb_ff);
					`CAD_OFS_ENABLES: begin
						if (wstrb_ff[1] && wstrb_ff[0]) en_ff[c] <= wdata_ff[9:0];
					end
					`CAD_OFS_SCAN: begin
						// Group 0 is out of range and ignored
						if (wstrb_ff[0] && wdata_ff[3:0] != 4'h0) grp_ff[c] <= wdata_ff[3:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Sweep sequencer: one group per sweep pulse
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_ff        <= 16'h0000;
			sw_ff         <= CAD_SW_IDLE;
			grp_cur_ff    <= `CAD_RST_GROUP;
			scan_start_ff <= 1'b0;
		end else begin
			scan_start_ff <= 1'b0;
			case (sw_ff)
				CAD_SW_IDLE: begin
					div_ff <= (div_ff == `CAD_SCAN_DIV) ? 16'h0000 : div_ff + 16'h0001;
					if (div_ff == `CAD_SCAN_DIV) sw_ff <= CAD_SW_RUN;
				end
				CAD_SW_RUN: begin
					scan_start_ff <= 1'b1;
					sw_ff         <= CAD_SW_DONE;
				end
				CAD_SW_DONE: begin
					grp_cur_ff <= (grp_cur_ff == 4'hf) ? 4'h1 : grp_cur_ff + 4'h1;
					sw_ff      <= CAD_SW_IDLE;
				end
				default: sw_ff <= CAD_SW_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Reading path and alarm evaluation
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_ff <= '0;
		end else begin
			rd_ff <= rd_in;
			rd_ff.valid <= rd_in.valid && (rd_in.ch < 4'(NCH));
		end
	end

	wire [3:0]    rch = rd_ff.ch;     // Channel of current reading
	cad_enables_t ren;                // Its enables
	assign ren = en_ff[rch];
	wire rep_on = ren.diag_en || ren.fault_en; // Some response enabled

	cad_alarm_eval u_eval (
		.value   (rd_ff.value),
		.lim     (lim_ff[rch]),
		.hi_on   (rep_on && ren.hi_en),
		.lo_on   (rep_on && ren.lo_en),
		.hi_prev (diag_ff[rch][`CAD_DG_HI_BIT]),
		.lo_prev (diag_ff[rch][`CAD_DG_LO_BIT]),
		.hi_next (hi_nx),
		.lo_next (lo_nx)
	);

	// New diagnostic word for the channel being read
	always_comb begin
		nxt_diag                    = diag_ff[rch];
		nxt_diag[`CAD_DG_HI_BIT]    = hi_nx;
		nxt_diag[`CAD_DG_LO_BIT]    = lo_nx;
		nxt_diag[`CAD_DG_NEW_BIT]   = nxt_diag[`CAD_DG_NEW_BIT] | (rd_ff.ok & ren.new_en);
		nxt_diag[`CAD_DG_ERR_BIT]   = rd_ff.err_resp & ren.err_en;
		nxt_diag[`CAD_DG_BITF_BIT]  = nxt_diag[`CAD_DG_BITF_BIT] | (rd_ff.bit_fail & ren.bitf_en);
		nxt_diag[`CAD_DG_IIC_BIT]   = nxt_diag[`CAD_DG_IIC_BIT] |
			(rd_ff.invalid_input_condition_fault & ren.iic_en);
		nxt_diag[`CAD_DG_ICS_BIT]   = nxt_diag[`CAD_DG_ICS_BIT] | (rd_ff.ics_fail & ren.ics_en);
		nxt_diag[`CAD_DG_OPEN_BIT]  = nxt_diag[`CAD_DG_OPEN_BIT] | (ren.open_en & (!rd_ff.ok |
			nxt_diag[`CAD_DG_BITF_BIT] | nxt_diag[`CAD_DG_IIC_BIT] | nxt_diag[`CAD_DG_ICS_BIT]));
	end

	// Rising faults: one event per reading
	assign evt_raise = |(nxt_diag & ~diag_ff[rch] & 32'h7100_0013);

	// Diagnostic words: reading sets, scan clears latched bits
	// Kept with reporting off too, so hysteresis and event edges survive fault-only use
	for (genvar c = 0; c < NCH; c++) begin : g_diag
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				diag_ff[c] <= 32'h0000_0000;
			end else if (rd_ff.valid && rch == 4'(c)) begin
				diag_ff[c] <= nxt_diag;
			end else if (scan_done) begin
				diag_ff[c] <= diag_ff[c] & 32'h0100_0003;
			end
		end
	end

	// Fault log pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_evt_ff <= 1'b0;
			fault_ch_ff  <= 4'h0;
		end else begin
			fault_evt_ff <= rd_ff.valid && ren.fault_en && evt_raise;
			if (rd_ff.valid) fault_ch_ff <= rch;
		end
	end

	// ----------------------------------------
	// AXI4-Lite read side
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= 2'b00;
		end else if (!rvalid_ff && s_axi_arvalid) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
			case (s_axi_araddr)
				`CAD_OFS_STATUS:   rdata_ff <= status;
				`CAD_OFS_MODCTL:   rdata_ff <= {31'h0, mod_en_ff};
				`CAD_OFS_SCAN:     rdata_ff <= {28'h0, grp_ff[chsel_ff]};
				`CAD_OFS_CHSEL:    rdata_ff <= {28'h0, chsel_ff};
				`CAD_OFS_HI_THR:   rdata_ff <= lim_ff[chsel_ff].hi_thr;
				`CAD_OFS_LO_THR:   rdata_ff <= lim_ff[chsel_ff].lo_thr;
				`CAD_OFS_HI_DB:    rdata_ff <= lim_ff[chsel_ff].hi_db;
				`CAD_OFS_LO_DB:    rdata_ff <= lim_ff[chsel_ff].lo_db;
				`CAD_OFS_OFFSET:   rdata_ff <= lim_ff[chsel_ff].offset;
				`CAD_OFS_ENABLES:  rdata_ff <= {22'h0, en_ff[chsel_ff]};
				// Zero length or reporting off hides the diagnostic area
				`CAD_OFS_DIAG:     rdata_ff <= (diag_len_ff != 16'h0 && en_ff[chsel_ff].diag_en)
					? diag_ff[chsel_ff] : 32'h0000_0000;
				`CAD_OFS_DIAG_LEN: rdata_ff <= {16'h0, diag_len_ff};
				default:           rdata_ff <= 32'h0000_0000;
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
	assign s_axi_wready  = !w_ok_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign scan_group    = grp_cur_ff;
	assign scan_start    = scan_start_ff;
	assign fault_evt     = fault_evt_ff;
	assign fault_ch      = fault_ch_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_status_rsvd;
		@(posedge aclk) disable iff (!aresetn) (status & 32'hfffc_7ffe) == 32'h0;
	endproperty
	a_status_rsvd: assert property (p_status_rsvd) else $error("reserved status set");
	property p_ok_fail;
		@(posedge aclk) disable iff (!aresetn) (fail_ff != 3'h0) |-> !status[0];
	endproperty
	a_ok_fail: assert property (p_ok_fail) else $error("ok with failure");
	property p_wdog;
		@(posedge aclk) disable iff (!aresetn) fail_sync[2] |=> status[15];
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog not flagged");
	property p_ram;
		@(posedge aclk) disable iff (!aresetn) fail_sync[1] |=> status[16];
	endproperty
	a_ram: assert property (p_ram) else $error("ram failure not flagged");
	property p_if;
		@(posedge aclk) disable iff (!aresetn) fail_sync[0] |=> status[17];
	endproperty
	a_if: assert property (p_if) else $error("interface failure not flagged");
	property p_hi_off;
		@(posedge aclk) disable iff (!aresetn) !(rep_on && ren.hi_en) |-> !hi_nx;
	endproperty
	a_hi_off: assert property (p_hi_off) else $error("high alarm while disabled");
	property p_evt_off;
		@(posedge aclk) disable iff (!aresetn) (rd_ff.valid && !ren.fault_en) |=> !fault_evt;
	endproperty
	a_evt_off: assert property (p_evt_off) else $error("event while fault off");
	property p_new;
		@(posedge aclk) disable iff (!aresetn)
			(rd_ff.valid && rd_ff.ok && ren.diag_en && ren.new_en) |=> diag_ff[$past(rch)][23];
	endproperty
	a_new: assert property (p_new) else $error("new data not set");
endmodule

// ==== dv/cad_xdcr_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Transducer front end model
// ----------------------------------------
module cad_xdcr_model
	import cad_pkg::*;
(
	input  logic         aclk,
	output cad_reading_t rd_out
);
	// Nothing is valid until the bench asks for a reading
	initial rd_out = '0;

	// One reading, valid for a single cycle; payload inverted after it
	task automatic send(input logic [3:0] ch, input logic [31:0] v, input logic ok);
		@(posedge aclk);
		rd_out <= '{1'b1, ch, v, ok, 1'b0, 1'b0, 1'b0, 1'b0};
		@(posedge aclk);
		rd_out <= '{1'b0, ~ch, ~v, ~ok, 1'b1, 1'b1, 1'b1, 1'b1};
	endtask

	// Good reading that also carries fault flags {err, bitf, iic, ics}
	task automatic send_f(input logic [3:0] ch, input logic [31:0] v, input logic [3:0] f);
		@(posedge aclk);
		rd_out <= '{1'b1, ch, v, 1'b1, f[3], f[2], f[1], f[0]};
		@(posedge aclk);
		rd_out <= '{1'b0, ~ch, ~v, 1'b0, ~f[3], ~f[2], ~f[1], ~f[0]};
	endtask
endmodule

// ==== dv/cad_channel_alarm_diag_tb.sv ====
`timescale 1ns/1ps
`include "cad_regs.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR %s exp %h got %h", n, e, a); end end
module cad_channel_alarm_diag_tb;
	// ----------------------------------------
	// Stimulus and response signals
	// ----------------------------------------
	logic                 aclk = 0;
	logic                 aresetn = 0;
	logic [7:0]           awaddr = 0, araddr = 0;
	logic [31:0]          wdata = 0, rdata, seed = 32'hcf3b7bd4;
	logic [3:0]           wstrb = 0, scan_group, fault_ch, sg_exp = 4'h1;
	logic                 awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic                 awready, wready, bvalid, arready, rvalid;
	logic [1:0]           bresp, rresp;
	logic                 scan_done = 0, wdog_fail = 0, ram_fail = 0, if_fail = 0;
	logic                 scan_start, fault_evt;
	cad_pkg::cad_reading_t rd_in;
	logic [33:0]          eq[$], e;   // Expected {rresp, rdata}
	logic [3:0]           fq[$];      // Expected fault event channels
	logic [1:0]           bq[$];      // Expected write responses
	int                   fail_count = 0, comparisons = 0, cyc = 0;
	localparam logic [3:0] CH = 4'h3;

	always #5 aclk = ~aclk;

	cad_channel_alarm_diag i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .rd_in(rd_in),
		.scan_done(scan_done), .wdog_fail(wdog_fail), .ram_fail(ram_fail),
		.if_fail(if_fail), .scan_group(scan_group), .scan_start(scan_start),
		.fault_evt(fault_evt), .fault_ch(fault_ch));
	cad_xdcr_model i_xdcr (.aclk(aclk), .rd_out(rd_in));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// Verdict and end of run
	task automatic summarize;
		if (fail_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Write: address and data offered together, bready held until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
		logic pa, pw, pb, ta, tw, tk;
		pa = 1;
		pw = 1;
		pb = 1;
		bq.push_back(r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (pb) begin
			@(negedge aclk);
			ta = pa && awready;
			tw = pw && wready;
			tk = bvalid;
			@(posedge aclk);
			if (ta) begin
				awvalid <= 0;
				pa = 0;
			end
			if (tw) begin
				wvalid <= 0;
				pw = 0;
			end
			if (tk) begin
				bready <= 0;
				pb = 0;
			end
		end
	endtask

	// Read: expected result noted first, monitor compares it
	task automatic rd(input logic [7:0] a, input logic [33:0] x);
		logic pa, pb, ta, tk;
		pa = 1;
		pb = 1;
		eq.push_back(x);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (pb) begin
			@(negedge aclk);
			ta = pa && arready;
			tk = rvalid;
			@(posedge aclk);
			if (ta) begin
				arvalid <= 0;
				pa = 0;
			end
			if (tk) begin
				rready <= 0;
				pb = 0;
			end
		end
	endtask

	// One-cycle scan complete pulse from the host
	task automatic scan_pulse;
		@(posedge aclk);
		scan_done <= 1;
		@(posedge aclk);
		scan_done <= 0;
	endtask

	// ----------------------------------------
	// Output monitor and timeout
	// ----------------------------------------
	always @(posedge aclk) begin
		cyc++;
		if (rvalid && rready) begin
			e = eq.size() ? eq.pop_front() : 34'h3ffffffff;
			`CHK("rdata", e, {rresp, rdata})
		end
		if (bvalid && bready) begin
			e = bq.size() ? 34'(bq.pop_front()) : 34'h3;
			`CHK("bresp", e[1:0], bresp)
		end
		if (fault_evt) begin
			e = fq.size() ? 34'(fq.pop_front()) : 34'hf;
			`CHK("fault_ch", e[3:0], fault_ch)
		end
		if (scan_start) begin
			`CHK("scan_group", sg_exp, scan_group)
			sg_exp = (sg_exp == 4'hf) ? 4'h1 : sg_exp + 4'h1;
		end
		if (cyc == 20000) begin
			fail_count++;
			summarize();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		rd(`CAD_OFS_STATUS, 34'h1);
		rd(`CAD_OFS_HI_THR, 34'h40000);
		rd(`CAD_OFS_LO_THR, 34'h100);
		rd(`CAD_OFS_HI_DB, 34'h100);
		rd(`CAD_OFS_OFFSET, 34'h0);
		rd(`CAD_OFS_ENABLES, 34'h0);
		rd(8'h30, {2'b10, 32'h0});
		wr(8'h05, 32'h0, 2'b10);
		rd(`CAD_OFS_STATUS, 34'h1);
		wr(`CAD_OFS_MODCTL, 32'h0);
		rd(`CAD_OFS_STATUS, 34'h0);
		wr(`CAD_OFS_MODCTL, 32'h1);
		seed = xs(seed);
		wr(`CAD_OFS_LO_DB, seed & 32'hffff);
		rd(`CAD_OFS_LO_DB, {2'b00, seed & 32'hffff});
		wr(`CAD_OFS_LO_DB, 32'h100);
		// Default thresholds keep high above low
		wr(`CAD_OFS_CHSEL, CH);
		rd(`CAD_OFS_SCAN, 34'h1);
		wr(`CAD_OFS_SCAN, 32'h5);
		wr(`CAD_OFS_SCAN, 32'h0);
		rd(`CAD_OFS_SCAN, 34'h5);
		wr(`CAD_OFS_DIAG_LEN, 32'h1);
		wr(`CAD_OFS_OFFSET, 32'h100);
		wr(`CAD_OFS_ENABLES, 32'h3f0);
		fq.push_back(CH);
		i_xdcr.send(CH, 32'h3ff00, 1);
		rd(`CAD_OFS_DIAG, 34'h00800002);
		seed = xs(seed);
		i_xdcr.send(CH, {24'h3fe, seed[7:0]}, 1);
		rd(`CAD_OFS_DIAG, 34'h00800002);
		i_xdcr.send(CH, 32'h3fdff, 1);
		rd(`CAD_OFS_DIAG, 34'h00800000);
		scan_pulse();
		rd(`CAD_OFS_DIAG, 34'h0);
		fq.push_back(CH);
		i_xdcr.send(CH, 32'h0, 1);
		rd(`CAD_OFS_DIAG, 34'h00800001);
		i_xdcr.send(CH, 32'h100, 1);
		rd(`CAD_OFS_DIAG, 34'h00800001);
		i_xdcr.send(CH, 32'h101, 1);
		rd(`CAD_OFS_DIAG, 34'h00800000);
		fq.push_back(CH);
		i_xdcr.send(CH, 32'h101, 0);
		rd(`CAD_OFS_DIAG, 34'h00800010);
		scan_pulse();
		rd(`CAD_OFS_DIAG, 34'h0);
		wr(`CAD_OFS_ENABLES, 32'h3b0);
		i_xdcr.send(CH, 32'h7d000, 1);
		rd(`CAD_OFS_DIAG, 34'h00800000);
		i_xdcr.send_f(CH, 32'h7d000, 4'hf);
		rd(`CAD_OFS_DIAG, 34'h00800000);
		wr(`CAD_OFS_ENABLES, 32'h3bf);
		fq.push_back(CH);
		i_xdcr.send_f(CH, 32'h7d000, 4'hf);
		rd(`CAD_OFS_DIAG, 34'h71800010);
		scan_pulse();
		rd(`CAD_OFS_DIAG, 34'h01000000);
		wr(`CAD_OFS_DIAG_LEN, 32'h0);
		rd(`CAD_OFS_DIAG, 34'h0);
		@(posedge aclk);
		wdog_fail <= 1;
		ram_fail <= 1;
		if_fail <= 1;
		repeat (6) @(posedge aclk);
		rd(`CAD_OFS_STATUS, 34'h00038000);
		repeat (300) @(posedge aclk);
		`CHK("events_left", 32'h0, 32'(fq.size()))
		summarize();
	end
endmodule
